//--- verif/line_far_end.sv
// far-end line model feeding the receive pins
`timescale 1ns/100ps
module line_far_end (
   input wire logic mclk, // clock
   input wire logic rst, // async reset
   output loopback_pkg::bipolar_s rx_line_pair // receive pins
);
   // alternating marks every cycle, so a leak from the pins cannot match two different symbols
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) rx_line_pair <= 2'h2;
      else rx_line_pair <= {rx_line_pair.neg, rx_line_pair.pos};
   end
endmodule : line_far_end

//--- verif/local_loopback_control_chk.sv
// port-level checker for the local return-path block
`timescale 1ns/100ps
module local_loopback_control_chk #(
   parameter int FIFO_DEPTH = 8,
   parameter int LIU_RESET_LEN = 125
) (
   input wire logic mclk, // clock
   input wire logic rst, // async reset
   input wire logic ce, // clock enable
   input wire logic [8:0] reg_addr, // address
   input wire logic [7:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   input wire logic [7:0] reg_rdata, // read data
   input wire logic line_tick, // line strobe
   input wire logic enc_valid, // symbol valid
   input wire loopback_pkg::bipolar_s enc_sym, // encoder symbol
   input wire loopback_pkg::bipolar_s tx_line_pair, // line out
   input wire loopback_pkg::bipolar_s dec_sym, // decoder in
   input wire logic rx_jat_bypass, // rx attenuator skipped
   input wire logic [1:0] tx_clock_select, // clock source
   input wire logic tx_clock_hazard, // clock warning
   input wire logic line_interface_reset, // front end reset
   input wire logic sb_tick, // bus strobe
   input wire logic [4:0] sb_channel, // slot
   input wire loopback_pkg::sysbus_bit_s tx_system_bus, // bus in
   input wire loopback_pkg::sysbus_bit_s rx_system_bus // bus out
);
   logic [2:0] ret_r;
   logic ret_ok_r;
   logic [2:0] jat_r;
   logic [1:0] sbc_r [32];
   wire wr_en = ce && reg_wr;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   // return config mirror, unreset like the real one
   always_ff @(posedge mclk) if (wr_en && reg_addr == 9'h014) ret_r <= reg_wdata[2:0];
   // mirror trusted only once written since reset
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) ret_ok_r <= 1'h0;
      else if (wr_en && reg_addr == 9'h014) ret_ok_r <= 1'h1;
   end
   // attenuator and per-channel mirrors
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         jat_r <= 3'h0;
         for (int i = 0; i < 32; i++) sbc_r[i] <= 2'h0;
      end else if (wr_en && reg_addr == 9'h002) jat_r <= reg_wdata[2:0];
      else if (wr_en && reg_addr[8:5] == 4'h7) sbc_r[reg_addr[4:0]] <= reg_wdata[1:0];
   end
   sequence direct_tick;
      ce && line_tick && ret_ok_r && !jat_r[0] && enc_valid;
   endsequence
   sequence liu_busy;
      line_interface_reset [*2] ##[1:1000] !line_interface_reset;
   endsequence
   chk_framer_bypass: assert property (wr_en && reg_addr == 9'h014
      |=> rx_jat_bypass == $past(reg_wdata[1])) else $error("bypass flag wrong");
   chk_framer_path: assert property (direct_tick ##0 ret_r[1]
      |=> dec_sym == $past(enc_sym)) else $error("decoder not fed by encoder");
   chk_tx_unaffected: assert property (direct_tick ##0 (ret_r[0] || ret_r[1]) && !ret_r[2]
      |=> tx_line_pair == $past(enc_sym)) else $error("line output disturbed");
   chk_hazard_flag: assert property (ret_ok_r |-> tx_clock_hazard ==
      ((ret_r[0] || ret_r[1]) && tx_clock_select == 2'h1 && jat_r != 3'h7))
      else $error("clock hazard flag wrong");
   chk_pcm_return: assert property (ce && sb_tick && sbc_r[sb_channel][0]
      |=> rx_system_bus.pcm == $past(tx_system_bus.pcm)) else $error("pcm not returned");
   chk_sig_return: assert property (ce && sb_tick && sbc_r[sb_channel][1]
      |=> rx_system_bus.sig == $past(tx_system_bus.sig)) else $error("signaling not returned");
   chk_liu_reset: assert property (wr_en && reg_addr == 9'h020 && reg_wdata[7]
      |=> liu_busy) else $error("front end reset wrong");
   chk_return_readback: assert property (ce && reg_rd && reg_addr == 9'h014 && ret_ok_r
      |=> reg_rdata[2:0] == $past(ret_r)) else $error("return config readback wrong");
endmodule : local_loopback_control_chk
bind local_loopback_control local_loopback_control_chk #(.FIFO_DEPTH(FIFO_DEPTH),
   .LIU_RESET_LEN(LIU_RESET_LEN)) chk_u (.mclk(mclk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .line_tick(line_tick), .enc_valid(enc_valid), .enc_sym(enc_sym),
   .tx_line_pair(tx_line_pair), .dec_sym(dec_sym), .rx_jat_bypass(rx_jat_bypass),
   .tx_clock_select(tx_clock_select), .tx_clock_hazard(tx_clock_hazard),
   .line_interface_reset(line_interface_reset), .sb_tick(sb_tick), .sb_channel(sb_channel),
   .tx_system_bus(tx_system_bus), .rx_system_bus(rx_system_bus));

//--- verif/tb_local_loopback_control.sv
// self-checking bench for the local return-path block
`timescale 1ns/100ps
module tb_local_loopback_control;
   logic mclk = 0, rst = 1, ce = 1, reg_wr = 0, reg_rd = 0, line_tick = 0, enc_valid = 0;
   logic sb_tick = 0, enc_ready, rx_jat_bypass, tx_clock_hazard, line_interface_reset;
   logic [8:0] reg_addr = '0;
   logic [7:0] reg_wdata = '0, reg_rdata;
   logic [4:0] sb_channel = '0;
   logic [1:0] tx_clock_select;
   loopback_pkg::bipolar_s enc_sym = '0, rx_line_pair, tx_line_pair, dec_sym;
   loopback_pkg::sysbus_bit_s tx_system_bus = '0, rx_framer_bus = '0, rx_system_bus;
   int fails = 0, cmp_count = 0, cyc = 0;
   // 125 MHz clock
   always #4 mclk = ~mclk;
   line_far_end far_u (.mclk(mclk), .rst(rst), .rx_line_pair(rx_line_pair));
   local_loopback_control #(.LIU_RESET_LEN(4)) dut_u (.mclk(mclk), .rst(rst), .ce(ce),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .line_tick(line_tick), .enc_valid(enc_valid),
      .enc_ready(enc_ready), .enc_sym(enc_sym), .rx_line_pair(rx_line_pair),
      .tx_line_pair(tx_line_pair), .dec_sym(dec_sym), .rx_jat_bypass(rx_jat_bypass),
      .tx_clock_select(tx_clock_select), .tx_clock_hazard(tx_clock_hazard),
      .line_interface_reset(line_interface_reset), .sb_tick(sb_tick),
      .sb_channel(sb_channel), .tx_system_bus(tx_system_bus),
      .rx_framer_bus(rx_framer_bus), .rx_system_bus(rx_system_bus));
   task automatic results();
      if (fails == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results
   // hang guard, far above the roughly 130 cycles needed
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         results();
      end
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic wr(input logic [8:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'h1;
      @(posedge mclk);
      reg_wr <= 1'h0;
      #1;
   endtask : wr
   task automatic rd(input logic [8:0] a, input logic [7:0] exp);
      @(posedge mclk);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge mclk);
      reg_rd <= 1'h0;
      #1;
      chk(reg_rdata, exp);
   endtask : rd
   task automatic ltk(input logic [1:0] s);
      @(posedge mclk);
      enc_sym <= s;
      enc_valid <= 1'h1;
      line_tick <= 1'h1;
      @(posedge mclk);
      line_tick <= 1'h0;
      #1;
   endtask : ltk
   task automatic sbt(input logic [4:0] ch, input logic [1:0] t, input logic [1:0] f,
         input logic [1:0] e);
      @(posedge mclk);
      sb_channel <= ch;
      tx_system_bus <= t;
      rx_framer_bus <= f;
      sb_tick <= 1'h1;
      @(posedge mclk);
      sb_tick <= 1'h0;
      #1;
      chk(rx_system_bus, e);
   endtask : sbt
   // reset values, read-back and an unmapped place
   task automatic t_regs();
      wr(9'h014, 8'h00);
      rd(9'h014, 8'h00);
      rd(9'h002, 8'h00);
      rd(9'h01a, 8'h00);
      rd(9'h020, 8'h00);
      rd(9'h0e0, 8'h00);
      wr(9'h0ff, 8'h03);
      rd(9'h0ff, 8'h03);
      // a write while ce is low must not land
      @(posedge mclk);
      ce <= 1'h0;
      wr(9'h0ff, 8'h00);
      @(posedge mclk);
      ce <= 1'h1;
      rd(9'h0ff, 8'h03);
      wr(9'h003, 8'hff);
      rd(9'h003, 8'h00);
   endtask : t_regs
   // framer return alone, then beside remote line return
   task automatic t_framer();
      wr(9'h014, 8'h02);
      chk(rx_jat_bypass, 8'h01);
      ltk(2'h2);
      chk(dec_sym, 8'h02);
      chk(tx_line_pair, 8'h02);
      // a tick with no valid symbol returns an empty symbol
      @(posedge mclk);
      enc_valid <= 1'h0;
      line_tick <= 1'h1;
      @(posedge mclk);
      line_tick <= 1'h0;
      #1;
      chk(dec_sym, 8'h00);
      wr(9'h014, 8'h06);
      ltk(2'h1);
      chk(dec_sym, 8'h01);
      rd(9'h014, 8'h06);
   endtask : t_framer
   // analog return with the front-end reset around it
   task automatic t_analog();
      wr(9'h014, 8'h01);
      wr(9'h020, 8'h80);
      chk(line_interface_reset, 8'h01);
      rd(9'h020, 8'h01);
      repeat (5) @(posedge mclk);
      #1;
      chk(line_interface_reset, 8'h00);
      // two symbols so the alternating pins cannot match both
      for (int k = 1; k <= 2; k++) begin
         repeat (3) ltk(k[1:0]);
         chk(dec_sym, k[7:0]);
         chk(tx_line_pair, k[7:0]);
      end
      chk(rx_jat_bypass, 8'h00);
      wr(9'h014, 8'h00);
      wr(9'h020, 8'h80);
      repeat (6) @(posedge mclk);
   endtask : t_analog
   // transmit clock source while looped
   task automatic t_clock();
      wr(9'h014, 8'h02);
      wr(9'h01a, 8'h01);
      chk(tx_clock_select, 8'h01);
      chk(tx_clock_hazard, 8'h01);
      wr(9'h002, 8'h07);
      chk(tx_clock_hazard, 8'h00);
      wr(9'h002, 8'h00);
      wr(9'h01a, 8'h02);
      chk(tx_clock_hazard, 8'h00);
      wr(9'h01a, 8'h00);
   endtask : t_clock
   // per-channel pcm and signaling returns
   task automatic t_channel();
      wr(9'h0e3, 8'h01);
      wr(9'h0e4, 8'h02);
      sbt(5'h03, 2'h3, 2'h0, 2'h2);
      sbt(5'h04, 2'h3, 2'h0, 2'h1);
      sbt(5'h05, 2'h3, 2'h0, 2'h0);
      sbt(5'h03, 2'h1, 2'h2, 2'h0);
   endtask : t_channel
   // attenuator store fills while the line stalls
   task automatic t_fifo();
      wr(9'h014, 8'h02);
      wr(9'h002, 8'h03);
      repeat (10) @(posedge mclk);
      #1;
      chk(enc_ready, 8'h00);
      // new encoder value differs from the stored head, so a bypass shows
      ltk(2'h1);
      chk(dec_sym, 8'h02);
      wr(9'h002, 8'h00);
   endtask : t_fifo
   // a mid-run reset keeps the return config but clears the others
   task automatic t_reset();
      wr(9'h014, 8'h02);
      @(posedge mclk);
      rst <= 1'h1;
      repeat (2) @(posedge mclk);
      rst <= 1'h0;
      rd(9'h014, 8'h02);
      chk(rx_jat_bypass, 8'h01);
      rd(9'h0e3, 8'h00);
      wr(9'h014, 8'h00);
      rd(9'h014, 8'h00);
   endtask : t_reset
   initial begin
      repeat (5) @(posedge mclk);
      rst <= 1'h0;
      t_regs();
      t_framer();
      t_analog();
      t_clock();
      t_channel();
      t_fifo();
      t_reset();
      results();
   end
endmodule : tb_local_loopback_control

//--- verilog/local_loopback_control.sv
// local analog, framer and per-channel return paths with their registers
`timescale 1ns/100ps
module local_loopback_control #(
   parameter int FIFO_DEPTH = loopback_pkg::TX_FIFO_DEPTH,
   parameter int LIU_RESET_LEN = loopback_pkg::LIU_RESET_CYCLES
) (
   input wire logic mclk, // 125 MHz block clock
   input wire logic rst, // async reset, high
   input wire logic ce, // clock enable
   input wire logic [8:0] reg_addr, // register address
   input wire logic [7:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [7:0] reg_rdata, // read data, held
   input wire logic line_tick, // line bit-time strobe
   input wire logic enc_valid, // encoder symbol valid
   output logic enc_ready, // encoder may advance
   input wire loopback_pkg::bipolar_s enc_sym, // encoder symbol
   input wire loopback_pkg::bipolar_s rx_line_pair, // receive pins, async
   output loopback_pkg::bipolar_s tx_line_pair, // transmit pins
   output loopback_pkg::bipolar_s dec_sym, // decoder input symbol
   output logic rx_jat_bypass, // receive attenuator skipped
   output logic [1:0] tx_clock_select, // transmit clock source
   output logic tx_clock_hazard, // recovered clock used while looped
   output logic line_interface_reset, // receive interface in reset
   input wire logic sb_tick, // system-bus bit strobe
   input wire logic [4:0] sb_channel, // current time slot
   input wire loopback_pkg::sysbus_bit_s tx_system_bus, // transmit bus input
   input wire loopback_pkg::sysbus_bit_s rx_framer_bus, // receive framer output
   output loopback_pkg::sysbus_bit_s rx_system_bus // receive bus output
);
   logic [7:0] return_cfg_r;
   logic [7:0] jat_cfg_r;
   logic [7:0] clk_sel_r;
   logic [7:0] sbc_r [loopback_pkg::NUM_CHANNELS];
   logic [$clog2(LIU_RESET_LEN+1)-1:0] liu_cnt_r;
   loopback_pkg::bipolar_s rx_meta_r;
   loopback_pkg::bipolar_s rx_sync_r;
   loopback_pkg::bipolar_s liu_sym_r;
   loopback_pkg::bipolar_s front_end_in;
   loopback_pkg::bipolar_s tx_sym;
   loopback_pkg::bipolar_s fifo_out;
   logic tx_sym_valid;
   logic analog_return_en;
   logic framer_return_en;
   logic remote_line_return_en;
   logic tx_jitter_attenuator;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic wr_any;

   // shared address decode for the per-channel block
   function automatic logic is_sbc(input logic [8:0] a);
      return (a >= loopback_pkg::SBC_BASE_ADDR) && (a <= loopback_pkg::SBC_LAST_ADDR);
   endfunction : is_sbc

   assign wr_any = ce && reg_wr;

   // return path config has no reset term, so a loop can survive reset
   always_ff @(posedge mclk) begin
      if (wr_any && reg_addr == loopback_pkg::RETURN_CFG_ADDR) begin
         return_cfg_r <= reg_wdata;
      end
   end

   assign analog_return_en = return_cfg_r[loopback_pkg::ANALOG_BIT];
   assign framer_return_en = return_cfg_r[loopback_pkg::FRAMER_BIT];
   assign remote_line_return_en = return_cfg_r[loopback_pkg::REMOTE_BIT];

   // attenuator and clock select registers
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         jat_cfg_r <= loopback_pkg::JAT_CFG_RST;
         clk_sel_r <= loopback_pkg::CLK_SEL_RST;
      end else if (wr_any) begin
         if (reg_addr == loopback_pkg::JAT_CFG_ADDR) begin
            jat_cfg_r <= reg_wdata;
         end
         if (reg_addr == loopback_pkg::CLK_SEL_ADDR) begin
            clk_sel_r <= reg_wdata;
         end
      end
   end

   // per-channel control registers, one per time slot
   for (genvar ch = 0; ch < loopback_pkg::NUM_CHANNELS; ch++) begin : g_sbc
      always_ff @(posedge mclk or posedge rst) begin
         if (rst) begin
            sbc_r[ch] <= loopback_pkg::SBC_RST;
         end else if (wr_any && is_sbc(reg_addr) && reg_addr[4:0] == 5'(ch)) begin
            sbc_r[ch] <= reg_wdata;
         end
      end
   end

   // interface reset: writing the reset bit starts a fixed-length hold
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         liu_cnt_r <= '0;
      end else if (ce) begin
         if (wr_any && reg_addr == loopback_pkg::LIU_CFG_ADDR
             && reg_wdata[loopback_pkg::LIU_RESET_BIT]) begin
            liu_cnt_r <= ($bits(liu_cnt_r))'(LIU_RESET_LEN);
         end else if (liu_cnt_r != '0) begin
            liu_cnt_r <= liu_cnt_r - 1'b1;
         end
      end
   end
   assign line_interface_reset = (liu_cnt_r != '0);

   // register reads; unmapped addresses return zero
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         reg_rdata <= loopback_pkg::UNMAPPED_READ;
      end else if (ce && reg_rd) begin
         if (is_sbc(reg_addr)) begin
            reg_rdata <= sbc_r[reg_addr[4:0]];
         end else begin
            case (reg_addr)
               loopback_pkg::JAT_CFG_ADDR: reg_rdata <= jat_cfg_r;
               loopback_pkg::RETURN_CFG_ADDR: reg_rdata <= return_cfg_r;
               loopback_pkg::CLK_SEL_ADDR: reg_rdata <= clk_sel_r;
               loopback_pkg::LIU_CFG_ADDR: begin
                  reg_rdata <= 8'(line_interface_reset) << loopback_pkg::LIU_BUSY_BIT;
               end
               default: reg_rdata <= loopback_pkg::UNMAPPED_READ;
            endcase
         end
      end
   end

   // clock source guard: software must steer away from the recovered clock
   assign tx_clock_select = clk_sel_r[1:0];
   assign tx_clock_hazard = (analog_return_en || framer_return_en)
      && (clk_sel_r[1:0] == loopback_pkg::TXCLK_RECOVERED)
      && !(tx_jitter_attenuator && jat_cfg_r[loopback_pkg::FREE_RUN_BIT]);

   // transmit attenuator buffer sits before both line output and framer return
   assign tx_jitter_attenuator = jat_cfg_r[loopback_pkg::JAT_EN_BIT]
      && jat_cfg_r[loopback_pkg::JAT_TX_DIR_BIT];

   symbol_fifo #(
      .WIDTH($bits(loopback_pkg::bipolar_s)),
      .DEPTH(FIFO_DEPTH)
   ) u_tx_jat (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .flush(!tx_jitter_attenuator),
      .in_valid(enc_valid && tx_jitter_attenuator),
      .in_ready(fifo_in_ready),
      .in_data(enc_sym),
      .out_valid(fifo_out_valid),
      .out_ready(line_tick && tx_jitter_attenuator),
      .out_data(fifo_out)
   );

   // without the buffer the encoder is paced straight by the line tick
   assign enc_ready = tx_jitter_attenuator ? fifo_in_ready : line_tick;
   assign tx_sym = tx_jitter_attenuator ? fifo_out : enc_sym;
   assign tx_sym_valid = tx_jitter_attenuator ? fifo_out_valid : enc_valid;

   // receive pins cross in through two flops
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rx_meta_r <= '0;
         rx_sync_r <= '0;
      end else if (ce) begin
         rx_meta_r <= rx_line_pair;
         rx_sync_r <= rx_meta_r;
      end
   end

   // analog return swaps the pins for our own transmit symbols
   assign front_end_in = analog_return_en ? tx_line_pair : rx_sync_r;

   // receive front end symbol, cleared while the interface is in reset
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         liu_sym_r <= '0;
      end else if (ce) begin
         if (line_interface_reset) begin
            liu_sym_r <= '0;
         end else if (line_tick) begin
            liu_sym_r <= front_end_in;
         end
      end
   end

   // transmit line output; framer return leaves it untouched
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tx_line_pair <= '0;
      end else if (ce && line_tick) begin
         if (remote_line_return_en) begin
            tx_line_pair <= liu_sym_r;
         end else begin
            tx_line_pair <= tx_sym_valid ? tx_sym : '0;
         end
      end
   end

   // decoder input: returned encoder data or recovered line data
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         dec_sym <= '0;
      end else if (ce && line_tick) begin
         if (framer_return_en) begin
            dec_sym <= tx_sym_valid ? tx_sym : '0;
         end else begin
            dec_sym <= liu_sym_r;
         end
      end
   end
   assign rx_jat_bypass = framer_return_en;

   // per-channel return on the system bus, one bit time per tick
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rx_system_bus <= '0;
      end else if (ce && sb_tick) begin
         rx_system_bus.pcm <= sbc_r[sb_channel][loopback_pkg::PCM_RET_BIT]
            ? tx_system_bus.pcm : rx_framer_bus.pcm;
         rx_system_bus.sig <= sbc_r[sb_channel][loopback_pkg::SIG_RET_BIT]
            ? tx_system_bus.sig : rx_framer_bus.sig;
      end
   end
endmodule : local_loopback_control

//--- verilog/loopback_pkg.sv
// shared constants and carriers for the local return-path control block
package loopback_pkg;
   // register offsets in the 9-bit parallel port address space
   localparam logic [8:0] JAT_CFG_ADDR = 9'h002;
   localparam logic [8:0] RETURN_CFG_ADDR = 9'h014;
   localparam logic [8:0] CLK_SEL_ADDR = 9'h01a;
   localparam logic [8:0] LIU_CFG_ADDR = 9'h020;
   localparam logic [8:0] SBC_BASE_ADDR = 9'h0e0;
   localparam logic [8:0] SBC_LAST_ADDR = 9'h0ff;
   localparam int NUM_CHANNELS = 32;
   // return_path_config fields
   localparam int ANALOG_BIT = 0;
   localparam int FRAMER_BIT = 1;
   localparam int REMOTE_BIT = 2;
   // jitter_attenuator_config fields
   localparam int JAT_EN_BIT = 0;
   localparam int JAT_TX_DIR_BIT = 1;
   localparam int FREE_RUN_BIT = 2;
   // line_interface_config fields
   localparam int LIU_BUSY_BIT = 0;
   localparam int LIU_RESET_BIT = 7;
   // sysbus_channel_control fields
   localparam int PCM_RET_BIT = 0;
   localparam int SIG_RET_BIT = 1;
   // clock_input_select low field: transmit clock source
   localparam logic [1:0] TXCLK_PIN = 2'h0;
   localparam logic [1:0] TXCLK_RECOVERED = 2'h1;
   localparam logic [1:0] TXCLK_ADAPTER = 2'h2;
   // reset values
   localparam logic [7:0] JAT_CFG_RST = 8'h00;
   localparam logic [7:0] CLK_SEL_RST = 8'h00;
   localparam logic [7:0] LIU_CFG_RST = 8'h00;
   localparam logic [7:0] SBC_RST = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;
   // line-interface reset duration
   localparam int CLK_MHZ = 125;
   localparam int LIU_RESET_NS = 1000;
   localparam int LIU_RESET_CYCLES = (LIU_RESET_NS * CLK_MHZ + 999) / 1000;
   localparam int TX_FIFO_DEPTH = 8;
   // bipolar line symbol
   typedef struct packed {
      logic pos;
      logic neg;
   } bipolar_s;
   // one system-bus bit time
   typedef struct packed {
      logic pcm;
      logic sig;
   } sysbus_bit_s;
endpackage : loopback_pkg

//--- verilog/symbol_fifo.sv
// small elastic store used as the transmit jitter attenuator buffer
`timescale 1ns/100ps
module symbol_fifo #(
   parameter int WIDTH = 2,
   parameter int DEPTH = 8
) (
   input wire logic mclk, // block clock
   input wire logic rst, // async reset, high
   input wire logic ce, // clock enable
   input wire logic flush, // empty the store
   input wire logic in_valid, // write request
   output logic in_ready, // room available
   input wire logic [WIDTH-1:0] in_data, // write word
   output logic out_valid, // word available
   input wire logic out_ready, // read request
   output logic [WIDTH-1:0] out_data // head word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic push;
   logic pop;

   // honest full and empty from the occupancy count
   assign in_ready = (count_r != DEPTH[AW:0]);
   assign out_valid = (count_r != '0);
   assign out_data = mem_r[rd_ptr_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // storage, no reset needed on data
   always_ff @(posedge mclk) begin
      if (ce && push) begin
         mem_r[wr_ptr_r] <= in_data;
      end
   end

   // pointers and count
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else if (ce) begin
         if (flush) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            count_r <= '0;
         end else begin
            if (push) begin
               wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
               rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
         end
      end
   end
endmodule : symbol_fifo
